// file: hw/rsse_exec_core.sv
// Summary of operation
// RULE1 - Left rotate: carry into bit0, bit7 out
// RULE2 - Right rotate: carry into bit7, bit0 out
// RULE3 - Destination bit 0 to W, 1 to file
// RULE4 - File address 0..127, one destination bit
// RULE5 - Sleep clears watchdog count and prescaler
// RULE6 - Sleep clears power-down, sets time-out flag
// RULE7 - Sleep halts core until a wake event
// RULE8 - Literal minus W into W
// RULE9 - Literal subtract carry and digit carry
// RULE10 - File minus W to chosen destination
// RULE11 - File subtract carry and digit carry
// RULE12 - Subtracts set zero; rotates keep zero, DC
// RULE13 - One word, done within one instruction cycle
`timescale 1ns/100ps
`default_nettype none

module rsse_exec_core #(
    parameter int DATA_W = rsse_pkg::DATA_W,
    parameter int FDEPTH = rsse_pkg::FDEPTH
) (
    // Clock and reset
    input  wire logic                                mclk_i,
    input  wire logic                                arst_n_i,
    // Decoded instruction from the sequencer
    input  wire logic                                instr_valid_i,
    input  wire rsse_pkg::rsse_instr_type            instr_i,
    output logic                                     instr_ready_o,
    // Power management
    input  wire logic                                wake_i,
    output logic                                     sleep_o,
    output logic                                     watchdog_clear_o,
    // AXI4-Lite write address and data
    input  wire logic                                s_axi_awvalid,
    output logic                                     s_axi_awready,
    input  wire logic [rsse_pkg::AXI_ADDR_W-1:0]     s_axi_awaddr,
    input  wire logic                                s_axi_wvalid,
    output logic                                     s_axi_wready,
    input  wire logic [31:0]                         s_axi_wdata,
    input  wire logic [3:0]                          s_axi_wstrb,
    // AXI4-Lite write response
    output logic                                     s_axi_bvalid,
    input  wire logic                                s_axi_bready,
    output logic [1:0]                               s_axi_bresp,
    // AXI4-Lite read address and data
    input  wire logic                                s_axi_arvalid,
    output logic                                     s_axi_arready,
    input  wire logic [rsse_pkg::AXI_ADDR_W-1:0]     s_axi_araddr,
    output logic                                     s_axi_rvalid,
    input  wire logic                                s_axi_rready,
    output logic [31:0]                              s_axi_rdata,
    output logic [1:0]                               s_axi_rresp
);

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations
    rsse_pkg::rsse_state_type  state, next_state;      // Core sequencing
    rsse_pkg::rsse_instr_type  op_q, next_op_q;        // Instruction in flight
    rsse_pkg::rsse_status_type status, next_status;    // Flags
    logic [DATA_W-1:0]         work, next_work;        // Working register
    logic [rsse_pkg::FADDR_W-1:0] fsel, next_fsel;     // Software file select
    logic [DATA_W-1:0]         peek, next_peek;        // Last file value seen by software
    logic                      peek_pend, next_peek_pend; // Read port served software
    logic                      wd_clr, next_wd_clr;    // Watchdog clear pulse
    logic                      asleep, next_asleep;    // Oscillator halted
    logic                      wake_meta, wake_sync;   // Wake pin synchroniser

    logic                      accept;                 // Instruction taken this edge
    logic [rsse_pkg::FADDR_W-1:0] mem_raddr;           // File read address
    logic [DATA_W-1:0]         file_rdata;             // Registered file read data
    logic                      mem_we;                 // File write enable
    logic [rsse_pkg::FADDR_W-1:0] mem_waddr;           // File write address
    logic [DATA_W-1:0]         mem_wdata;              // File write data
    logic [DATA_W-1:0]         result;                 // Execution result
    logic [DATA_W:0]           diff;                   // Subtract with carry-out, set when no borrow
    logic [4:0]                ndiff;                  // Low nibble subtract
    logic [DATA_W-1:0]         minuend;                // Literal or file value

    // Bus side
    logic                      wr_take;                // Write address and data taken
    logic                      wr_hit;                 // Write lands on a register
    logic                      sw_wake;                // Software wake pulse
    logic                      bvalid, next_bvalid;
    logic [1:0]                bresp, next_bresp;
    logic                      rvalid, next_rvalid;
    logic [31:0]               rdata, next_rdata;
    logic [1:0]                rresp, next_rresp;

    ////////////////////////////////////////////////////////////////////////////////
    // File registers
    rsse_file_mem #(
        .WIDTH (DATA_W),
        .DEPTH (FDEPTH),
        .AW    (rsse_pkg::FADDR_W)
    ) u_file_mem (
        .mclk_i  (mclk_i),
        .we_i    (mem_we),
        .waddr_i (mem_waddr),
        .wdata_i (mem_wdata),
        .raddr_i (mem_raddr),
        .rdata_o (file_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Wake pin synchroniser, first stage read only by the second
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wake_meta <= 1'b0;
            wake_sync <= 1'b0;
        end else begin
            wake_meta <= wake_i;
            wake_sync <= wake_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Handshakes; a bus write stalls the sequencer for one edge so neither side starves
    assign wr_take       = s_axi_awvalid && s_axi_wvalid && !bvalid && (state != rsse_pkg::ST_EXEC);
    assign s_axi_awready = wr_take;
    assign s_axi_wready  = wr_take;
    assign instr_ready_o = (state == rsse_pkg::ST_IDLE) && !wr_take;  // RULE7
    assign accept        = instr_valid_i && instr_ready_o;
    assign sw_wake       = wr_take && (s_axi_awaddr == rsse_pkg::OFS_CTRL) && s_axi_wstrb[0]
                           && s_axi_wdata[rsse_pkg::CTRL_WAKE_BIT];

    // Read port follows the incoming instruction, otherwise the software select
    assign mem_raddr = accept ? instr_i.faddr : fsel;  // RULE4

    // Outputs straight from flops
    assign sleep_o          = asleep;
    assign watchdog_clear_o = wd_clr;

    ////////////////////////////////////////////////////////////////////////////////
    // Datapath: operand choice, shared subtractor, result select
    always_comb begin
        minuend = (op_q.op == rsse_pkg::OP_LIT_SUB) ? op_q.literal : file_rdata;
        // Two's complement subtract, carry out means no borrow
        diff  = {1'b0, minuend} + {1'b0, ~work} + 9'h001;                     // RULE8 RULE10
        ndiff = {1'b0, minuend[3:0]} + {1'b0, ~work[3:0]} + 5'h01;
        case (op_q.op)
            rsse_pkg::OP_ROT_LEFT:  result = {file_rdata[DATA_W-2:0], status.carry};  // RULE1
            rsse_pkg::OP_ROT_RIGHT: result = {status.carry, file_rdata[DATA_W-1:1]};  // RULE2
            default:                result = diff[DATA_W-1:0];
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Core next state: execution, sleep and software writes
    always_comb begin
        next_state     = state;
        next_op_q      = op_q;
        next_status    = status;
        next_work      = work;
        next_fsel      = fsel;
        next_peek      = peek_pend ? file_rdata : peek;
        next_peek_pend = !accept;
        next_wd_clr    = 1'b0;
        next_asleep    = asleep;
        mem_we         = 1'b0;
        mem_waddr      = op_q.faddr;
        mem_wdata      = result;

        // Software writes; never in EXEC, no clash
        wr_hit = 1'b1;
        if (wr_take && s_axi_wstrb[0]) begin
            case (s_axi_awaddr)
                rsse_pkg::OFS_CTRL:   wr_hit = 1'b1;
                rsse_pkg::OFS_WORK:   next_work = s_axi_wdata[DATA_W-1:0];
                rsse_pkg::OFS_STATUS: next_status = s_axi_wdata[rsse_pkg::STATUS_W-1:0];
                rsse_pkg::OFS_FSEL:   next_fsel = s_axi_wdata[rsse_pkg::FADDR_W-1:0];
                rsse_pkg::OFS_FDATA: begin
                    mem_we    = 1'b1;
                    mem_waddr = fsel;
                    mem_wdata = s_axi_wdata[DATA_W-1:0];
                end
                default:              wr_hit = 1'b0;
            endcase
        end else if (wr_take) begin
            wr_hit = (s_axi_awaddr == rsse_pkg::OFS_CTRL) || (s_axi_awaddr == rsse_pkg::OFS_WORK)
                  || (s_axi_awaddr == rsse_pkg::OFS_STATUS) || (s_axi_awaddr == rsse_pkg::OFS_FSEL)
                  || (s_axi_awaddr == rsse_pkg::OFS_FDATA);
        end

        case (state)
            // Take one word; file value read on this edge
            rsse_pkg::ST_IDLE: begin
                if (accept) begin
                    next_op_q = instr_i;  // RULE13
                    if (instr_i.op == rsse_pkg::OP_SLEEP) begin
                        next_wd_clr                 = 1'b1;  // RULE5
                        next_status.power_down_flag = 1'b0;  // RULE6
                        next_status.time_out_flag   = 1'b1;  // RULE6
                        next_asleep                 = 1'b1;  // RULE7
                        next_state                  = rsse_pkg::ST_SLEEP;
                    end else begin
                        next_state = rsse_pkg::ST_EXEC;
                    end
                end
            end
            // Second clock: compute and retire
            rsse_pkg::ST_EXEC: begin
                next_state = rsse_pkg::ST_IDLE;  // RULE13
                case (op_q.op)
                    rsse_pkg::OP_ROT_LEFT: begin
                        next_status.carry = file_rdata[DATA_W-1];  // RULE1 RULE12
                        mem_we            = op_q.dest;            // RULE3
                        if (!op_q.dest) next_work = result;       // RULE3
                    end
                    rsse_pkg::OP_ROT_RIGHT: begin
                        next_status.carry = file_rdata[0];        // RULE2 RULE12
                        mem_we            = op_q.dest;            // RULE3
                        if (!op_q.dest) next_work = result;       // RULE3
                    end
                    rsse_pkg::OP_LIT_SUB: begin
                        next_work                    = result;          // RULE8
                        next_status.carry            = diff[DATA_W];    // RULE9
                        next_status.digit_carry_flag = ndiff[4];        // RULE9
                        next_status.zero             = (result == '0);  // RULE12
                    end
                    rsse_pkg::OP_FILE_SUB: begin
                        next_status.carry            = diff[DATA_W];    // RULE11
                        next_status.digit_carry_flag = ndiff[4];        // RULE11
                        next_status.zero             = (result == '0);  // RULE12
                        mem_we                       = op_q.dest;       // RULE3 RULE10
                        if (!op_q.dest) next_work = result;             // RULE3 RULE10
                    end
                    default: ;  // Foreign operations have no effect here
                endcase
            end
            // Halted until pin or software wake
            rsse_pkg::ST_SLEEP: begin
                if (wake_sync || sw_wake) begin  // RULE7
                    next_asleep = 1'b0;
                    next_state  = rsse_pkg::ST_IDLE;
                end
            end
            default: begin
                next_asleep = 1'b0;
                next_state  = rsse_pkg::ST_IDLE;
            end
        endcase
    end

    // Core registers
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state     <= rsse_pkg::ST_IDLE;
            op_q      <= '0;
            status    <= rsse_pkg::STATUS_RST;
            work      <= rsse_pkg::WORK_RST;
            fsel      <= rsse_pkg::FSEL_RST;
            peek      <= '0;
            peek_pend <= 1'b0;
            wd_clr    <= 1'b0;
            asleep    <= 1'b0;
        end else begin
            state     <= next_state;
            op_q      <= next_op_q;
            status    <= next_status;
            work      <= next_work;
            fsel      <= next_fsel;
            peek      <= next_peek;
            peek_pend <= next_peek_pend;
            wd_clr    <= next_wd_clr;
            asleep    <= next_asleep;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bus responses: one write and one read outstanding at most
    assign s_axi_arready = !rvalid;
    assign s_axi_bvalid  = bvalid;
    assign s_axi_bresp   = bresp;
    assign s_axi_rvalid  = rvalid;
    assign s_axi_rdata   = rdata;
    assign s_axi_rresp   = rresp;

    always_comb begin
        next_bvalid = bvalid;
        next_bresp  = bresp;
        next_rvalid = rvalid;
        next_rdata  = rdata;
        next_rresp  = rresp;
        // Write response one edge after the take
        if (wr_take) begin
            next_bvalid = 1'b1;
            next_bresp  = wr_hit ? rsse_pkg::RESP_OKAY : rsse_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        // Read data one edge later; unmapped reads zero, error
        if (s_axi_arvalid && !rvalid) begin
            next_rvalid = 1'b1;
            next_rresp  = rsse_pkg::RESP_OKAY;
            next_rdata  = 32'h0000_0000;
            case (s_axi_araddr)
                rsse_pkg::OFS_CTRL:   next_rdata[rsse_pkg::CTRL_ASLEEP_BIT] = asleep;
                rsse_pkg::OFS_WORK:   next_rdata[DATA_W-1:0] = work;
                rsse_pkg::OFS_STATUS: next_rdata[rsse_pkg::STATUS_W-1:0] = status;
                rsse_pkg::OFS_FSEL:   next_rdata[rsse_pkg::FADDR_W-1:0] = fsel;
                rsse_pkg::OFS_FDATA:  next_rdata[DATA_W-1:0] = peek;
                default:              next_rresp = rsse_pkg::RESP_SLVERR;
            endcase
        end else if (s_axi_rready) begin
            next_rvalid = 1'b0;
        end
    end

    // Bus response registers
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bvalid <= 1'b0;
            bresp  <= rsse_pkg::RESP_OKAY;
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= rsse_pkg::RESP_OKAY;
        end else begin
            bvalid <= next_bvalid;
            bresp  <= next_bresp;
            rvalid <= next_rvalid;
            rdata  <= next_rdata;
            rresp  <= next_rresp;
        end
    end

endmodule : rsse_exec_core

`default_nettype wire

// file: hw/rsse_file_mem.sv
`timescale 1ns/100ps
`default_nettype none

// File register array, one write and one read port, registered read data
module rsse_file_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 128,
    parameter int AW    = 7
) (
    // Clock
    input  wire logic             mclk_i,
    // Write port
    input  wire logic             we_i,
    input  wire logic [AW-1:0]    waddr_i,
    input  wire logic [WIDTH-1:0] wdata_i,
    // Read port
    input  wire logic [AW-1:0]    raddr_i,
    output logic      [WIDTH-1:0] rdata_o
);

    logic [WIDTH-1:0] mem [DEPTH];  // Storage, no reset so it maps to RAM

    ////////////////////////////////////////////////////////////////////////////////
    // Write, then read of the old value when addresses collide
    always_ff @(posedge mclk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end

endmodule : rsse_file_mem

`default_nettype wire

// file: pkg/rsse_pkg.sv
`default_nettype none

package rsse_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Datapath widths
    localparam int DATA_W  = 8;    // File and working register width
    localparam int FADDR_W = 7;    // File address field, 0 to 127
    localparam int FDEPTH  = 128;  // Number of file registers

    ////////////////////////////////////////////////////////////////////////////////
    // Decoded operations from the sequencer
    typedef enum logic [2:0] {
        OP_NONE        = 3'h0,  // Accepted, no effect
        OP_ROT_LEFT    = 3'h1,  // rotate_left_through_carry
        OP_ROT_RIGHT   = 3'h2,  // rotate_right_through_carry
        OP_LIT_SUB     = 3'h3,  // literal_minus_working
        OP_FILE_SUB    = 3'h4,  // file_minus_working
        OP_SLEEP       = 3'h5   // Enter sleep
    } rsse_op_type;

    // One decoded instruction word
    typedef struct packed {
        rsse_op_type        op;       // Operation
        logic [FADDR_W-1:0] faddr;    // File register address
        logic               dest;     // 0 to working register, 1 to file
        logic [DATA_W-1:0]  literal;  // Eight-bit literal
    } rsse_instr_type;

    // Status flags, packed in register bit order
    typedef struct packed {
        logic time_out_flag;     // Bit 4
        logic power_down_flag;   // Bit 3
        logic zero;              // Bit 2
        logic digit_carry_flag;  // Bit 1
        logic carry;             // Bit 0
    } rsse_status_type;

    // Core sequencing states, Gray along IDLE, EXEC, SLEEP
    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_EXEC  = 2'h1,
        ST_SLEEP = 2'h3
    } rsse_state_type;

    localparam int STATUS_W = 5;  // Status register width

    ////////////////////////////////////////////////////////////////////////////////
    // Register map, byte addresses
    localparam int AXI_ADDR_W = 12;
    localparam logic [AXI_ADDR_W-1:0] OFS_CTRL   = 12'h000;  // Bit0 write wake, read asleep
    localparam logic [AXI_ADDR_W-1:0] OFS_WORK   = 12'h004;  // Working register
    localparam logic [AXI_ADDR_W-1:0] OFS_STATUS = 12'h008;  // Status flags
    localparam logic [AXI_ADDR_W-1:0] OFS_FSEL   = 12'h00C;  // File register select
    localparam logic [AXI_ADDR_W-1:0] OFS_FDATA  = 12'h010;  // Selected file register

    // Field positions
    localparam int CTRL_WAKE_BIT  = 0;
    localparam int CTRL_ASLEEP_BIT = 0;

    // Reset values
    localparam logic [DATA_W-1:0]   WORK_RST   = 8'h00;
    localparam logic [STATUS_W-1:0] STATUS_RST = 5'h18;  // Time-out and power-down set
    localparam logic [FADDR_W-1:0]  FSEL_RST   = 7'h00;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : rsse_pkg

`default_nettype wire

// file: testbench/rsse_exec_core_asserts.sv
`timescale 1ns/100ps
`default_nettype none
// Port-level checks
module rsse_exec_core_asserts (
    // Clock and reset
    input wire logic                     mclk_i,
    input wire logic                     arst_n_i,
    // Instruction port, power and bus writes
    input wire logic                     instr_valid_i,
    input wire rsse_pkg::rsse_instr_type instr_i,
    input wire logic                     instr_ready_o,
    input wire logic                     sleep_o,
    input wire logic                     watchdog_clear_o,
    input wire logic                     s_axi_awvalid,
    input wire logic                     s_axi_wvalid,
    input wire logic                     s_axi_bvalid,
    input wire logic                     s_axi_bready,
    input wire logic [1:0]               s_axi_bresp
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    ////////////////////////////////////////
    wire logic take = instr_valid_i && instr_ready_o;              // Word accepted
    wire logic nap  = take && instr_i.op == rsse_pkg::OP_SLEEP;    // Sleep accepted
    wire logic alu  = take && !nap;                                // Anything else
    // A bus write may hold ready low one more cycle
    a_exec_busy: assert property (alu |=> !instr_ready_o)
        else $error("ready during execute");
    a_exec_done: assert property (alu |=> ##1 (instr_ready_o || s_axi_awvalid && s_axi_wvalid))
        else $error("instruction overran its cycle");
    a_sleep_enter: assert property (nap |=> sleep_o && watchdog_clear_o)
        else $error("sleep not entered");
    a_clear_pulse: assert property (watchdog_clear_o |=> !watchdog_clear_o)
        else $error("watchdog clear too long");
    a_clear_cause: assert property (watchdog_clear_o |-> $past(nap))
        else $error("watchdog clear without sleep");
    a_asleep_idle: assert property (sleep_o |-> !instr_ready_o)
        else $error("instruction accepted asleep");
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_bvalid_ends: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
endmodule : rsse_exec_core_asserts
`default_nettype wire

// file: testbench/rsse_exec_core_test.sv
`timescale 1ns/100ps
`default_nettype none
module rsse_exec_core_test;
    logic        mclk_i = 1'h0, arst_n_i = 1'h0, wake_i = 1'h0;
    logic        instr_valid_i, instr_ready_o, sleep_o, watchdog_clear_o;
    rsse_pkg::rsse_instr_type instr_i;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'h1;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    int          num_errors = 0, total_checks = 0;
    int          w, f, st, k, r, sel, c;  // Model state
    ////////////////////////////////////////
    rsse_exec_core dut (.*);
    rsse_seq_model seq (.mclk_i, .instr_valid_o(instr_valid_i), .instr_o(instr_i), .instr_ready_i(instr_ready_o));
    initial forever #25 mclk_i = ~mclk_i;
    task automatic complete_run;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run
    function automatic logic sig(int n);
        case (n)
            0: return s_axi_awready;
            1: return s_axi_bvalid;
            2: return s_axi_arready;
            3: return s_axi_rvalid;
            default: return sleep_o;
        endcase
    endfunction : sig
    // Bounded wait; timeout fails the run
    task automatic wait_for(int n, logic v);
        int i;
        for (i = 0; i < 200 && sig(n) !== v; i++) @(negedge mclk_i);
        if (i == 200) begin
            num_errors++;
            complete_run();
        end
    endtask : wait_for
    task automatic check(string what, int exp, logic [31:0] got);
        total_checks++;
        if (got !== exp[31:0]) begin
            num_errors++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check
    // Late bready: pending response must hold
    task automatic bus_wr(logic [11:0] a, int d, logic [1:0] resp);
        @(posedge mclk_i);
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid  <= 1'h1;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        @(negedge mclk_i);
        wait_for(0, 1'h1);
        @(posedge mclk_i);
        s_axi_awvalid <= 1'h0;
        s_axi_wvalid  <= 1'h0;
        @(negedge mclk_i);
        wait_for(1, 1'h1);
        @(posedge mclk_i);
        s_axi_bready <= 1'h1;
        @(negedge mclk_i);
        check("bresp", resp, s_axi_bresp);
        @(posedge mclk_i);
        s_axi_bready <= 1'h0;
    endtask : bus_wr
    task automatic bus_rd(logic [11:0] a, int exp, logic [1:0] resp, string what);
        @(posedge mclk_i);
        s_axi_arvalid <= 1'h1;
        s_axi_araddr  <= a;
        s_axi_rready  <= 1'h1;
        @(negedge mclk_i);
        wait_for(2, 1'h1);
        @(posedge mclk_i);
        s_axi_arvalid <= 1'h0;
        @(negedge mclk_i);
        wait_for(3, 1'h1);
        check(what, exp, s_axi_rdata);
        check("rresp", resp, s_axi_rresp);
        @(posedge mclk_i);
        s_axi_rready <= 1'h0;
    endtask : bus_rd
    // Results settle within four cycles
    task automatic run(rsse_pkg::rsse_op_type op, logic d);
        bit ok;
        seq.issue('{op, sel[6:0], d, k[7:0]}, ok);
        if (!ok) begin
            num_errors++;
            complete_run();
        end
        repeat (4) @(posedge mclk_i);
    endtask : run
    ////////////////////////////////////////
    initial begin
        logic d;
        c = $urandom(1);
        repeat (8) @(posedge mclk_i);
        arst_n_i <= 1'h1;
        bus_rd(rsse_pkg::OFS_STATUS, rsse_pkg::STATUS_RST, rsse_pkg::RESP_OKAY, "status");
        bus_rd(rsse_pkg::OFS_WORK, 0, rsse_pkg::RESP_OKAY, "work");
        bus_wr(12'h020, 0, rsse_pkg::RESP_SLVERR);
        bus_rd(12'h020, 0, rsse_pkg::RESP_SLVERR, "unmapped");
        for (int i = 0; i < 48; i++) begin
            d = $urandom;
            sel = $urandom % 128;
            w = $urandom % 256;
            f = $urandom % 256;
            k = $urandom % 256;
            st = $urandom % 32;
            bus_wr(rsse_pkg::OFS_WORK, w, rsse_pkg::RESP_OKAY);
            bus_wr(rsse_pkg::OFS_FSEL, sel, rsse_pkg::RESP_OKAY);
            bus_wr(rsse_pkg::OFS_FDATA, f, rsse_pkg::RESP_OKAY);
            bus_wr(rsse_pkg::OFS_STATUS, st, rsse_pkg::RESP_OKAY);
            run(rsse_pkg::rsse_op_type'(1 + i % 4), d);
            c = (i % 4 == 2) ? k : f;  // Subtract operand
            case (i % 4)
                0: r = ((f << 1) | (st & 1)) & 255;
                1: r = (f >> 1) | ((st & 1) << 7);
                default: r = (c - w) & 255;
            endcase
            if (i % 4 < 2)
                st = (st & 'h1E) | ((i % 4 == 0) ? f >> 7 : f & 1);
            else
                st = (st & 'h18) | (r == 0) << 2 | ((w & 15) <= (c & 15)) << 1 | (w <= c);
            if (d && i % 4 != 2)
                f = r;
            else
                w = r;
            bus_rd(rsse_pkg::OFS_WORK, w, rsse_pkg::RESP_OKAY, "work");
            bus_rd(rsse_pkg::OFS_STATUS, st, rsse_pkg::RESP_OKAY, "status");
            bus_rd(rsse_pkg::OFS_FDATA, f, rsse_pkg::RESP_OKAY, "file");
        end
        // Sleep, wake by software, then sleep again and wake by the pin
        st = (st & 7) | 'h10;
        run(rsse_pkg::OP_SLEEP, 1'h0);
        bus_rd(rsse_pkg::OFS_CTRL, 1, rsse_pkg::RESP_OKAY, "asleep");
        bus_rd(rsse_pkg::OFS_STATUS, st, rsse_pkg::RESP_OKAY, "status");
        bus_wr(rsse_pkg::OFS_CTRL, 1, rsse_pkg::RESP_OKAY);
        bus_rd(rsse_pkg::OFS_CTRL, 0, rsse_pkg::RESP_OKAY, "awake");
        run(rsse_pkg::OP_SLEEP, 1'h1);
        wake_i <= 1'h1;
        wait_for(4, 1'h0);
        @(posedge mclk_i);
        wake_i <= 1'h0;
        bus_rd(rsse_pkg::OFS_STATUS, st, rsse_pkg::RESP_OKAY, "status");
        complete_run();
    end
endmodule : rsse_exec_core_test
bind rsse_exec_core rsse_exec_core_asserts u_chk (.*);
`default_nettype wire

// file: testbench/rsse_seq_model.sv
`timescale 1ns/100ps
`default_nettype none
// Sequencer stand-in: offers decoded words and holds each until taken or 50 cycles pass
module rsse_seq_model (
    // Clock
    input  wire logic                    mclk_i,
    // Decoded word towards the core
    output logic                         instr_valid_o,
    output var rsse_pkg::rsse_instr_type instr_o,
    input  wire logic                    instr_ready_i
);
    ////////////////////////////////////////
    initial begin
        instr_valid_o = 1'h0;
        instr_o       = '0;
    end
    // Ready sampled mid-cycle, clear of the edge
    task automatic issue(input rsse_pkg::rsse_instr_type word, output bit ok);
        int i;
        @(posedge mclk_i);
        instr_valid_o <= 1'h1;
        instr_o       <= word;
        @(negedge mclk_i);
        for (i = 0; i < 50 && instr_ready_i !== 1'h1; i++) @(negedge mclk_i);
        @(posedge mclk_i);
        instr_valid_o <= 1'h0;
        instr_o       <= ~word;  // Released bus shows no stale word
        ok = (i < 50);
    endtask : issue
endmodule : rsse_seq_model
`default_nettype wire
